// File: src/supervisor_map.vh
// constants shared by the supervisor watchdog and timebase core
`ifndef SUPERVISOR_MAP_VH
`define SUPERVISOR_MAP_VH

// clock rate and printed times
`define PCLK_KHZ          25000
`define RST_SHORT_MS      50
`define RST_LONG_MS       200
`define WD_SHORT_MS       100
`define WD_LONG_MS        1600

// external timebase counts, in timebase clocks
`define EXT_WD_NORMAL     26'h0000400
`define EXT_WD_AFTER_RST  26'h0001000
`define EXT_RST_SHORT     26'h0000200
`define EXT_RST_LONG      26'h0000800

// widths
`define CNT_W             26
`define ADDR_W            8
`define PIN_W             9

// register byte offsets
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h04
`define OFS_COUNT         8'h08

// control field and reset value
`define CTRL_LONG_RST     0
`define CTRL_RESET_VAL    1'h0

// status fields
`define ST_RESET_ACT      0
`define ST_LOW_LINE_N     1
`define ST_TIMEOUT_N      2
`define ST_BACKUP         3
`define ST_EXT_MODE       4
`define ST_LONG_PHASE     5
`define ST_WD_ARMED       6

`endif

// File: src/pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 1
) (
  input  wire         clk,      // sampling clock
  input  wire         rst_n,    // async reset, active low
  input  wire [W-1:0] pin_in,   // raw asynchronous levels
  input  wire [W-1:0] init_val, // unused; reset loads zero into every stage and the output
  output reg  [W-1:0] pin_out   // filtered level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer     i;

  // first stage feeds only the second; output moves when stages two and three agree
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= {W{1'b0}};
      s2_q    <= {W{1'b0}};
      s3_q    <= {W{1'b0}};
      pin_out <= {W{1'b0}};
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1)
        if (s2_q[i] == s3_q[i])
          pin_out[i] <= s3_q[i];
    end
  end
endmodule

// File: src/tick_counter.v
// tick counter with clear and limit compare
`timescale 1ns/1ps
`include "supervisor_map.vh"
module tick_counter (
  input  wire              clk,   // block clock
  input  wire              rst_n, // async reset, active low
  input  wire              clr,   // hold count at zero
  input  wire              tick,  // one timebase step
  input  wire [`CNT_W-1:0] limit, // steps until done
  output wire              done,  // count reached limit
  output reg  [`CNT_W-1:0] count  // current count
);
  // saturates at the limit so done stays up until cleared
  assign done = (count >= limit);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= {`CNT_W{1'b0}};
    else if (clr)
      count <= {`CNT_W{1'b0}};
    else if (tick && !done)
      count <= count + {{(`CNT_W-1){1'b0}}, 1'b1};
  end
endmodule

// File: src/supervisor_watchdog_gating.v
// supervisor core: reset timing, watchdog, status flags, chip-enable gating
// Functional notes
// - gated chip-enable follows input, forced high while supply below threshold
// - backup-active flag high while output supply comes from backup
// - supply-low flag low below threshold, high at once when above
// - active-high reset output is always inverse of active-low reset
// - select high or undriven uses internal timing, low uses external timebase
// - external clock on timebase input times reset pulse and watchdog
// - internal mode reset lasts 50 ms, or 200 ms on long variant
// - internal mode timebase input level picks 100 ms or 1.6 s
// - long 1.6 s timeout applies directly after any reset
// - timeout status low when heartbeat holds level past timeout
// - timeout status returns high on next heartbeat transition
// - undriven or mid-level heartbeat disables watchdog, status stays high
// - timeout status forced high when supply-low flag goes low
// - reset asserted on low supply, supply below backup, or watchdog timeout
// - every heartbeat transition restarts the watchdog count
// - short internal timeout effective only after first heartbeat edge post-reset
// - external clock: 1024 normal, 4096 after reset, reset 512 or 2048
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "supervisor_map.vh"
module supervisor_watchdog_gating #(
  parameter integer RST_SHORT_CYC = `RST_SHORT_MS * `PCLK_KHZ, // 50 ms in pclk cycles
  parameter integer RST_LONG_CYC  = `RST_LONG_MS * `PCLK_KHZ,  // 200 ms in pclk cycles
  parameter integer WD_SHORT_CYC  = `WD_SHORT_MS * `PCLK_KHZ,  // 100 ms in pclk cycles
  parameter integer WD_LONG_CYC   = `WD_LONG_MS * `PCLK_KHZ    // 1.6 s in pclk cycles
) (
  input  wire               pclk,                  // block clock, 25 MHz
  input  wire               presetn,               // async reset, active low
  input  wire [`ADDR_W-1:0] paddr,                 // apb byte address
  input  wire               psel,                  // apb select
  input  wire               penable,               // apb access phase
  input  wire               pwrite,                // apb write
  input  wire [31:0]        pwdata,                // apb write data
  output reg  [31:0]        prdata,                // apb read data
  output wire               pready,                // apb ready
  output wire               pslverr,               // apb error on unmapped address
  input  wire               ce_in_n,               // incoming chip enable, active low
  input  wire               heartbeat_input,       // heartbeat level
  input  wire               heartbeat_valid,       // heartbeat driven, not floating
  input  wire               timebase_select,       // timebase select level
  input  wire               timebase_select_valid, // timebase select driven
  input  wire               timebase_input,        // timebase level or external clock
  input  wire               timebase_input_valid,  // timebase input driven
  input  wire               supply_below_thr,      // comparator: supply below threshold
  input  wire               supply_below_batt,     // comparator: supply below backup
  output reg                ce_out_n,              // gated chip enable, active low
  output reg                backup_active,         // output supply taken from backup
  output reg                low_line_n,            // supply-low flag, active low
  output reg                reset_out_n,           // reset, active low
  output reg                reset_out,             // reset, active high
  output reg                timeout_status_n       // watchdog timeout status, active low
);
  // reset sequencer states, one-hot
  localparam [2:0] ST_HOLD  = 3'h1;
  localparam [2:0] ST_PULSE = 3'h2;
  localparam [2:0] ST_RUN   = 3'h4;

  // integer limits held at 32 bits here, narrowed to CNT_W at each use
  wire [31:0] rst_short_w = RST_SHORT_CYC;
  wire [31:0] rst_long_w  = RST_LONG_CYC;
  wire [31:0] wd_short_w  = WD_SHORT_CYC;
  wire [31:0] wd_long_w   = WD_LONG_CYC;

  reg  [2:0]        state_q;
  reg  [2:0]        state_d;
  reg               long_rst_q;
  reg               long_phase_q;
  reg               hb_prev_q;
  reg               tb_prev_q;
  wire [`PIN_W-1:0] pins_raw;
  wire [`PIN_W-1:0] pins_s;
  wire              ce_in_s;
  wire              hb_s;
  wire              hb_valid_s;
  wire              sel_s;
  wire              sel_valid_s;
  wire              tb_s;
  wire              tb_valid_s;
  wire              below_thr_s;
  wire              below_batt_s;
  wire              ext_mode;
  wire              tb_level;
  wire              tick;
  wire              supply_bad;
  wire              hb_edge;
  wire              wd_armed;
  wire              wd_expire;
  wire              rst_done;
  wire              wd_done;
  wire [`CNT_W-1:0] rst_count;
  wire [`CNT_W-1:0] wd_count;
  reg  [`CNT_W-1:0] rst_limit;
  reg  [`CNT_W-1:0] wd_limit;
  wire              reset_active;

  // every pin crosses into pclk through the filtered synchroniser
  assign pins_raw = {ce_in_n, heartbeat_input, heartbeat_valid,
                     timebase_select, timebase_select_valid,
                     timebase_input, timebase_input_valid,
                     supply_below_thr, supply_below_batt};

  // comparator flags and tri-level pins synchronised before use
  pin_sync #(
    .W (`PIN_W)
  ) u_pin_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .pin_in   (pins_raw),
    .init_val ({`PIN_W{1'b0}}),
    .pin_out  (pins_s)
  );

  // unpack synchronised levels
  assign ce_in_s      = pins_s[8];
  assign hb_s         = pins_s[7];
  assign hb_valid_s   = pins_s[6];
  assign sel_s        = pins_s[5];
  assign sel_valid_s  = pins_s[4];
  assign tb_s         = pins_s[3];
  assign tb_valid_s   = pins_s[2];
  assign below_thr_s  = pins_s[1];
  assign below_batt_s = pins_s[0];

  // undriven select counts as high, so internal timing is the fallback
  assign ext_mode = sel_valid_s & ~sel_s;
  // undriven timebase input counts as high, picking the long period
  assign tb_level = tb_s | ~tb_valid_s;

  // external mode steps once per rising timebase edge, internal mode every pclk
  assign tick = ext_mode ? (tb_s & ~tb_prev_q) : 1'b1;

  // either comparator condition holds the reset
  assign supply_bad = below_thr_s | below_batt_s;

  // heartbeat transition in either direction, only while driven
  assign hb_edge  = hb_valid_s & (hb_s ^ hb_prev_q);
  assign wd_armed = hb_valid_s & (state_q == ST_RUN);

  // an edge in the same cycle as expiry counts as service, so it wins
  assign wd_expire = wd_armed & wd_done & ~hb_edge;

  assign reset_active = (state_q != ST_RUN);

  // reset active period by mode and variant
  always @*
  begin
    if (ext_mode)
      rst_limit = long_rst_q ? `EXT_RST_LONG : `EXT_RST_SHORT;
    else if (long_rst_q)
      rst_limit = rst_long_w[`CNT_W-1:0];
    else
      rst_limit = rst_short_w[`CNT_W-1:0];
  end

  // watchdog period: long right after reset, else by mode and timebase level
  always @*
  begin
    if (ext_mode)
      wd_limit = long_phase_q ? `EXT_WD_AFTER_RST : `EXT_WD_NORMAL;
    else if (long_phase_q || tb_level)
      wd_limit = wd_long_w[`CNT_W-1:0];
    else
      wd_limit = wd_short_w[`CNT_W-1:0];
  end

  // reset pulse timer runs only in the pulse state
  tick_counter u_rst_timer (
    .clk   (pclk),
    .rst_n (presetn),
    .clr   (state_q != ST_PULSE),
    .tick  (tick),
    .limit (rst_limit),
    .done  (rst_done),
    .count (rst_count)
  );

  // watchdog timer cleared during reset, on each heartbeat edge, and when floating
  tick_counter u_wd_timer (
    .clk   (pclk),
    .rst_n (presetn),
    .clr   (~wd_armed | hb_edge),
    .tick  (tick),
    .limit (wd_limit),
    .done  (wd_done),
    .count (wd_count)
  );

  // reset sequencer next state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:
      begin
        if (!supply_bad)
          state_d = ST_PULSE;
      end
      ST_PULSE:
      begin
        if (supply_bad)
          state_d = ST_HOLD;
        else if (rst_done)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (supply_bad)
          state_d = ST_HOLD;
        else if (wd_expire)
          state_d = ST_PULSE;
      end
      default:
        state_d = ST_HOLD;
    endcase
  end

  // power-up starts with a full reset pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_PULSE;
    else
      state_q <= state_d;
  end

  // edge history for heartbeat and external timebase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hb_prev_q <= 1'b0;
      tb_prev_q <= 1'b0;
    end
    else
    begin
      hb_prev_q <= hb_s;
      tb_prev_q <= tb_s;
    end
  end

  // long period holds from any reset until the first heartbeat edge after it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      long_phase_q <= 1'b1;
    else if (reset_active)
      long_phase_q <= 1'b1;
    else if (hb_edge)
      long_phase_q <= 1'b0;
  end

  // timeout status: low on expiry, high on heartbeat edge, low supply or float
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timeout_status_n <= 1'b1;
    else if (below_thr_s)
      timeout_status_n <= 1'b1;
    else if (!hb_valid_s)
      timeout_status_n <= 1'b1;
    else if (hb_edge)
      timeout_status_n <= 1'b1;
    else if (wd_expire)
      timeout_status_n <= 1'b0;
  end

  // both reset polarities load from one term so they never disagree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_out_n <= 1'b0;
      reset_out   <= 1'b1;
    end
    else
    begin
      reset_out_n <= (state_d == ST_RUN);
      reset_out   <= (state_d != ST_RUN);
    end
  end

  // supply flags and chip-enable gate; registered, so a few cycles of latency
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_line_n    <= 1'b0;
      backup_active <= 1'b0;
      ce_out_n      <= 1'b1;
    end
    else
    begin
      low_line_n    <= ~below_thr_s;
      backup_active <= below_batt_s;
      ce_out_n      <= supply_bad | ce_in_s;
    end
  end

  // apb slave: zero wait states, unmapped addresses answer with an error
  wire acc        = psel & penable;
  wire hit_ctrl   = (paddr == `OFS_CTRL);
  wire hit_status = (paddr == `OFS_STATUS);
  wire hit_count  = (paddr == `OFS_COUNT);
  wire mapped     = hit_ctrl | hit_status | hit_count;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // control register: long reset variant select
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      long_rst_q <= `CTRL_RESET_VAL;
    else if (acc && pwrite && hit_ctrl)
      long_rst_q <= pwdata[`CTRL_LONG_RST];
  end

  // read data captured in the setup cycle so it stands through the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      prdata <= 32'h00000000;
      if (hit_ctrl)
        prdata[`CTRL_LONG_RST] <= long_rst_q;
      else if (hit_status)
      begin
        prdata[`ST_RESET_ACT]  <= reset_active;
        prdata[`ST_LOW_LINE_N] <= low_line_n;
        prdata[`ST_TIMEOUT_N]  <= timeout_status_n;
        prdata[`ST_BACKUP]     <= backup_active;
        prdata[`ST_EXT_MODE]   <= ext_mode;
        prdata[`ST_LONG_PHASE] <= long_phase_q;
        prdata[`ST_WD_ARMED]   <= wd_armed;
      end
      else if (hit_count)
        prdata[`CNT_W-1:0] <= wd_count;
    end
  end
endmodule

// File: verif/supervisor_watchdog_gating_properties.sv
// assertion checker for the supervisor core, bound to its ports
`timescale 1ns/1ps
module supervisor_checker #(
  parameter integer WD_SHORT_CYC = 100 // short watchdog period in pclk cycles
) (
  input wire pclk,              // block clock
  input wire presetn,           // async reset, active low
  input wire ce_in_n,           // chip enable in
  input wire heartbeat_input,   // heartbeat level
  input wire heartbeat_valid,   // heartbeat driven
  input wire supply_below_thr,  // supply below threshold
  input wire supply_below_batt, // supply below backup
  input wire ce_out_n,          // gated chip enable
  input wire backup_active,     // backup flag
  input wire low_line_n,        // supply-low flag
  input wire reset_out_n,       // reset, active low
  input wire reset_out,         // reset, active high
  input wire timeout_status_n   // watchdog status
);
  reg [31:0] idle_q;
  reg        hb_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // heartbeat idle time at the pin; the sync delay can only make it overcount
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_q <= 32'h0;
      hb_q   <= 1'b0;
    end
    else
    begin
      hb_q   <= heartbeat_input;
      idle_q <= (!reset_out_n || hb_q != heartbeat_input) ? 32'h0 : idle_q + 32'h1;
    end
  end

  rst_inverse_a: assert property (reset_out != reset_out_n)
    else $error("reset outputs not complementary");
  ce_pass_a: assert property (($stable(ce_in_n) && !supply_below_thr && !supply_below_batt) [*8]
    |-> ce_out_n == ce_in_n) else $error("chip enable not passed");
  ce_force_a: assert property ((!low_line_n || backup_active) [*2] |-> ce_out_n)
    else $error("chip enable not blocked");
  backup_flag_a: assert property ($stable(supply_below_batt) [*8]
    |-> backup_active == supply_below_batt) else $error("backup flag wrong");
  line_flag_a: assert property ($stable(supply_below_thr) [*8]
    |-> low_line_n != supply_below_thr) else $error("supply-low flag wrong");
  wd_early_a: assert property ($fell(timeout_status_n)
    |-> idle_q >= WD_SHORT_CYC - 2) else $error("watchdog expired early");
  wd_clear_a: assert property (!timeout_status_n && heartbeat_valid && hb_q != heartbeat_input
    |-> ##[1:8] timeout_status_n) else $error("status not cleared");
  wd_float_a: assert property (!heartbeat_valid [*8] |-> timeout_status_n)
    else $error("status low with heartbeat floating");
  wd_line_a: assert property (!low_line_n [*3] |-> timeout_status_n)
    else $error("status low during low supply");
  wd_reset_a: assert property ($fell(timeout_status_n) |-> ##[0:3] !reset_out_n)
    else $error("no reset after timeout");
  line_reset_a: assert property ((!low_line_n || backup_active) [*3] |-> !reset_out_n)
    else $error("no reset on bad supply");

  cover property ($fell(timeout_status_n));
  cover property ($rose(reset_out_n));
  cover property (backup_active && !low_line_n);
endmodule

bind supervisor_watchdog_gating supervisor_checker #(.WD_SHORT_CYC(WD_SHORT_CYC)) chk (
  .pclk(pclk), .presetn(presetn), .ce_in_n(ce_in_n), .heartbeat_input(heartbeat_input),
  .heartbeat_valid(heartbeat_valid), .supply_below_thr(supply_below_thr),
  .supply_below_batt(supply_below_batt), .ce_out_n(ce_out_n),
  .backup_active(backup_active), .low_line_n(low_line_n), .reset_out_n(reset_out_n),
  .reset_out(reset_out), .timeout_status_n(timeout_status_n));

// File: verif/host_model.sv
// host side model: heartbeat toggling and external timebase clock
`timescale 1ns/1ps
module host_model (
  input  wire pclk,     // bench clock
  input  wire hb_run,   // toggle heartbeat freely
  input  wire hb_kick,  // one heartbeat edge
  input  wire ext_run,  // run the timebase clock
  input  wire tb_level, // static timebase level
  output reg  hb,       // heartbeat level
  output wire tb_out    // timebase pin
);
  reg [5:0] div_q;
  reg [1:0] clk_q;

  initial
  begin
    hb    = 1'b0;
    div_q = 6'h00;
    clk_q = 2'h0;
  end

  // toggling every 40 cycles stays well inside the short period
  always @(posedge pclk)
  begin
    div_q <= (div_q == 6'h27) ? 6'h00 : div_q + 6'h01;
    clk_q <= ext_run ? clk_q + 2'h1 : 2'h0;
    if ((hb_run && div_q == 6'h27) || hb_kick)
      hb <= ~hb;
  end
  // clock of four pclk periods, standing at the static level when stopped
  assign tb_out = ext_run ? clk_q[1] : tb_level;
endmodule

// File: verif/test_supervisor_watchdog_gating.sv
// self-checking bench for the supervisor core
`timescale 1ns/1ps
module test_supervisor_watchdog_gating;
  reg         pclk, presetn, psel, penable, pwrite, ce_in_n, hb_valid, e;
  reg         ts_sel, ts_sel_v, ts_lvl, ts_v, thr, batt, hb_run, hb_kick, ext_run;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [6:0]  rows [0:4];
  wire [31:0] prdata;
  wire        pready, pslverr, hb, ts_in, ce_out_n, backup_active;
  wire        low_line_n, reset_out_n, reset_out, timeout_status_n;
  integer     n_errors, n_compared, cyc, n, i, bad;

  supervisor_watchdog_gating #(.RST_SHORT_CYC(50), .RST_LONG_CYC(200), .WD_SHORT_CYC(100),
    .WD_LONG_CYC(1600)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ce_in_n(ce_in_n), .heartbeat_input(hb), .heartbeat_valid(hb_valid),
    .timebase_select(ts_sel), .timebase_select_valid(ts_sel_v), .timebase_input(ts_in),
    .timebase_input_valid(ts_v), .supply_below_thr(thr), .supply_below_batt(batt),
    .ce_out_n(ce_out_n), .backup_active(backup_active), .low_line_n(low_line_n),
    .reset_out_n(reset_out_n), .reset_out(reset_out), .timeout_status_n(timeout_status_n));
  host_model host (.pclk(pclk), .hb_run(hb_run), .hb_kick(hb_kick), .ext_run(ext_run),
    .tb_level(ts_lvl), .hb(hb), .tb_out(ts_in));

  // measured times carry a few cycles of pin synchroniser delay, hence tol
  // 33 bits wide so an error flag can ride above a full data word
  task check(input [32:0] got, input [32:0] exp, input integer tol);
    begin
      n_compared = n_compared + 1;
      if (^got === 1'bx || (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp)))
      begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task complete_run;
    begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // one apb transfer, held until pready is seen high
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // cycles until a chosen output reaches level v
  task wait_on(input integer s, input v);
    begin
      n = 0;
      while ((s == 0 ? reset_out_n : s == 1 ? timeout_status_n : low_line_n) !== v)
      begin
        @(posedge pclk);
        n = n + 1;
      end
    end
  endtask

  // supply dip, then length of reset after the supply flag returns
  task dip;
    begin
      thr <= 1'b1;
      repeat (10) @(posedge pclk);
      thr <= 1'b0;
      wait_on(2, 1'b1);
      wait_on(0, 1'b1);
    end
  endtask

  // count cycles with the timeout status low
  task watch(input integer len);
    begin
      bad = 0;
      repeat (len)
      begin
        @(posedge pclk);
        bad = bad + (timeout_status_n !== 1'b1);
      end
    end
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, ce_in_n, hb_valid, ts_lvl, ts_v, thr, batt} = 10'h0;
    // select driven high: internal timing until the external test drives it low
    {hb_run, hb_kick, ext_run, ts_sel, ts_sel_v, paddr, pwdata} = 45'h30000000000;
    {n_errors, n_compared, cyc} = 96'h0;
    // thr batt ce_in | ce_out low_line backup reset
    rows[0] = 7'h04;
    rows[1] = 7'h1c;
    rows[2] = 7'h49;
    rows[3] = 7'h2f;
    rows[4] = 7'h7b;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_on(0, 1'b1);
    for (i = 0; i < 5; i = i + 1)
    begin
      {thr, batt, ce_in_n} <= rows[i][6:4];
      repeat (10) @(posedge pclk);
      check(ce_out_n, rows[i][3], 0);
      check(low_line_n, rows[i][2], 0);
      check(backup_active, rows[i][1], 0);
      check({reset_out, reset_out_n}, {rows[i][0], !rows[i][0]}, 0);
    end
    $display("table done");
    {thr, batt} <= 2'h0;
    wait_on(2, 1'b1);
    wait_on(0, 1'b1);
    check(n, 50, 3);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check({e, rd}, 33'h1, 0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[3:0], 4'h6, 0);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check({e, rd}, 33'h100000000, 0);
    dip;
    check(n, 200, 3);
    apb(1'b1, 8'h00, 32'h0);
    $display("timing done");
    {hb_valid, ts_v} <= 2'h3;
    dip;
    wait_on(1, 1'b0);
    check(n, 1600, 8);
    repeat (4) @(posedge pclk);
    check(reset_out_n, 1'b0, 0);
    wait_on(0, 1'b1);
    check(timeout_status_n, 1'b0, 0);
    repeat (20) @(posedge pclk);
    hb_kick <= 1'b1;
    @(posedge pclk);
    hb_kick <= 1'b0;
    repeat (10) @(posedge pclk);
    check(timeout_status_n, 1'b1, 0);
    wait_on(1, 1'b0);
    check(n, 90, 8);
    wait_on(0, 1'b1);
    hb_run <= 1'b1;
    repeat (60) @(posedge pclk);
    watch(600);
    check(bad, 0, 0);
    {hb_run, hb_valid} <= 2'h0;
    watch(2000);
    check(bad, 0, 0);
    $display("watchdog done");
    hb_valid <= 1'b1;
    wait_on(1, 1'b0);
    thr <= 1'b1;
    repeat (10) @(posedge pclk);
    check(timeout_status_n, 1'b1, 0);
    {hb_valid, ts_sel, ext_run} <= 3'h1;
    dip;
    check(n, 2048, 12);
    $display("external timebase done");
    complete_run;
  end
endmodule
